// [verilog/jmex_core.sv]
`timescale 1ns/1ps
`include "jmex_map.svh"
module jmex_core
    import jmex_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // write address channel
    input wire logic [`JMEX_AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address channel
    input wire logic [`JMEX_AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ==========================================
    // helpers

    // merge the two low byte lanes into a 16-bit register
    function automatic jmex_word_t apply_strb(input jmex_word_t old, input logic [31:0] data,
                                              input logic [3:0] strb);
        jmex_word_t res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction

    // true when the offset names a register of this block
    function automatic logic is_mapped(input logic [`JMEX_AXI_AW-1:0] a);
        return (a == `JMEX_OFF_INSTR) || (a == `JMEX_OFF_PC) || (a == `JMEX_OFF_SR) ||
               (a == `JMEX_OFF_SRC) || (a == `JMEX_OFF_DST) || (a == `JMEX_OFF_STAT);
    endfunction

    // ==========================================
    // state
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic aw_have_q;
    logic w_have_q;
    logic [`JMEX_AXI_AW-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    jmex_word_t instr_q;
    logic exec_q;
    jmex_word_t pc_q;
    jmex_word_t sr_q;
    jmex_word_t src_q;
    jmex_word_t dst_q;
    jmex_word_t stat_q;
    jmex_word_t pc_d;
    jmex_word_t dst_d;
    jmex_word_t stat_d;
    logic [31:0] rdata_d;
    logic do_write;
    logic aw_hs;
    logic w_hs;
    logic wr_instr;
    logic wr_pc;
    logic wr_sr;
    logic wr_src;
    logic wr_dst;

    jmex_exec_if ex ();

    // ==========================================
    // execution unit hookup
    assign ex.instr = instr_q;
    assign ex.pc = pc_q;
    assign ex.sr = sr_q;
    assign ex.src = src_q;

    jmex_branch_unit u_unit (
        .ex(ex.unit)
    );

    // ==========================================
    // write decode
    assign aw_hs = s_axi_awvalid && awready_q;
    assign w_hs = s_axi_wvalid && wready_q;
    // both halves present and no answer pending
    assign do_write = aw_have_q && w_have_q && !bvalid_q;
    assign wr_instr = do_write && (awaddr_q == `JMEX_OFF_INSTR);
    assign wr_pc = do_write && (awaddr_q == `JMEX_OFF_PC);
    assign wr_sr = do_write && (awaddr_q == `JMEX_OFF_SR);
    assign wr_src = do_write && (awaddr_q == `JMEX_OFF_SRC);
    assign wr_dst = do_write && (awaddr_q == `JMEX_OFF_DST);

    // ==========================================
    // write address capture
    // address kept in a flop so a late data beat still finds it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awready_q <= 1'b1;
            aw_have_q <= 1'b0;
            awaddr_q <= '0;
        end else if (aw_hs) begin
            awready_q <= 1'b0;
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_have_q <= 1'b0;
        end else if (bvalid_q && s_axi_bready) begin
            awready_q <= 1'b1;
        end
    end

    // ==========================================
    // write data capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wready_q <= 1'b1;
            w_have_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (w_hs) begin
            wready_q <= 1'b0;
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_have_q <= 1'b0;
        end else if (bvalid_q && s_axi_bready) begin
            wready_q <= 1'b1;
        end
    end

    // ==========================================
    // write response; channels reopen only after it is taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= `JMEX_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(awaddr_q) ? `JMEX_RESP_OKAY : `JMEX_RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ==========================================
    // instruction latch and one-cycle execute strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            instr_q <= `JMEX_RST_WORD;
            exec_q <= 1'b0;
        end else begin
            exec_q <= wr_instr;
            if (wr_instr) begin
                instr_q <= apply_strb(instr_q, wdata_q, wstrb_q);
            end
        end
    end

    // ==========================================
    // program counter; a no-op still steps past itself
    // software load wins, though it never meets an execute strobe
    always_comb begin
        pc_d = pc_q;
        if (wr_pc) begin
            pc_d = apply_strb(pc_q, wdata_q, wstrb_q);
        end else if (exec_q) begin
            pc_d = ex.next_pc;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_q <= `JMEX_RST_PC;
        end else begin
            pc_q <= pc_d;
        end
    end

    // ==========================================
    // status word: only software writes it, execution never does
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sr_q <= `JMEX_RST_SR;
        end else if (wr_sr) begin
            sr_q <= apply_strb(sr_q, wdata_q, wstrb_q);
        end
    end

    // ==========================================
    // source operand, left intact by a copy
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src_q <= `JMEX_RST_WORD;
        end else if (wr_src) begin
            src_q <= apply_strb(src_q, wdata_q, wstrb_q);
        end
    end

    // ==========================================
    // destination operand
    // a copy into the constant generator leaves it untouched
    always_comb begin
        dst_d = dst_q;
        if (wr_dst) begin
            dst_d = apply_strb(dst_q, wdata_q, wstrb_q);
        end else if (exec_q && ex.dst_write) begin
            dst_d = ex.move_value;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dst_q <= `JMEX_RST_WORD;
        end else begin
            dst_q <= dst_d;
        end
    end

    // ==========================================
    // result of the last executed word
    // one-hot kind plus taken, so software sees a single class
    always_comb begin
        stat_d = `JMEX_RST_WORD;
        stat_d[`JMEX_ST_TAKEN] = ex.taken;
        stat_d[`JMEX_ST_JUMP] = (ex.kind == jmex_kind_jump);
        stat_d[`JMEX_ST_MOVE] = (ex.kind == jmex_kind_move);
        stat_d[`JMEX_ST_IDLE] = (ex.kind == jmex_kind_idle);
        // unknown words leave pc, sr, src and dst as they were
        stat_d[`JMEX_ST_UNSUP] = (ex.kind == jmex_kind_other);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stat_q <= `JMEX_RST_WORD;
        end else if (exec_q) begin
            stat_q <= stat_d;
        end
    end

    // ==========================================
    // read mux; registers sit in the low half, upper half zero
    always_comb begin
        case (s_axi_araddr)
            `JMEX_OFF_INSTR: rdata_d = {16'h0000, instr_q};
            `JMEX_OFF_PC: rdata_d = {16'h0000, pc_q};
            `JMEX_OFF_SR: rdata_d = {16'h0000, sr_q};
            `JMEX_OFF_SRC: rdata_d = {16'h0000, src_q};
            `JMEX_OFF_DST: rdata_d = {16'h0000, dst_q};
            `JMEX_OFF_STAT: rdata_d = {16'h0000, stat_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // ==========================================
    // read channel; data sampled at the address handshake
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rresp_q <= `JMEX_RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= is_mapped(s_axi_araddr) ? `JMEX_RESP_OKAY : `JMEX_RESP_SLVERR;
            rdata_q <= rdata_d;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // ==========================================
    // outputs straight from flops
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
endmodule

// [inc/jmex_map.svh]
`ifndef JMEX_MAP_SVH
`define JMEX_MAP_SVH

// ==========================================
// register offsets (byte addresses)
`define JMEX_AXI_AW 8
`define JMEX_OFF_INSTR 8'h00
`define JMEX_OFF_PC 8'h04
`define JMEX_OFF_SR 8'h08
`define JMEX_OFF_SRC 8'h0c
`define JMEX_OFF_DST 8'h10
`define JMEX_OFF_STAT 8'h14

// ==========================================
// reset values
`define JMEX_RST_PC 16'h0000
`define JMEX_RST_SR 16'h0000
`define JMEX_RST_WORD 16'h0000

// ==========================================
// status word bit positions
`define JMEX_SR_C 0
`define JMEX_SR_Z 1
`define JMEX_SR_N 2
`define JMEX_SR_V 8

// ==========================================
// result status bits
`define JMEX_ST_TAKEN 0
`define JMEX_ST_JUMP 1
`define JMEX_ST_MOVE 2
`define JMEX_ST_IDLE 3
`define JMEX_ST_UNSUP 4

// ==========================================
// instruction encoding
`define JMEX_JUMP_OP 3'h1
`define JMEX_MOVE_OP 4'h4
`define JMEX_MOVE_BYTE 6
`define JMEX_CG_REG 4'h3
`define JMEX_IDLE_WORD 16'h4303
`define JMEX_INSTR_STEP 16'h0002
`define JMEX_COND_NE 3'h0
`define JMEX_COND_EQ 3'h1
`define JMEX_COND_NC 3'h2
`define JMEX_COND_C 3'h3
`define JMEX_COND_N 3'h4
`define JMEX_COND_GE 3'h5
`define JMEX_COND_L 3'h6
`define JMEX_COND_AL 3'h7

// ==========================================
// bus answers
`define JMEX_RESP_OKAY 2'h0
`define JMEX_RESP_SLVERR 2'h2
`endif

// [inc/jmex_pkg.sv]
package jmex_pkg;
    typedef logic [15:0] jmex_word_t;
    typedef enum logic [1:0] {jmex_kind_other, jmex_kind_jump, jmex_kind_move, jmex_kind_idle} jmex_kind_t;
endpackage

// [inc/jmex_exec_if.sv]
`timescale 1ns/1ps
interface jmex_exec_if;
    import jmex_pkg::*;
    jmex_word_t instr;
    jmex_word_t pc;
    jmex_word_t sr;
    jmex_word_t src;
    jmex_kind_t kind;
    logic taken;
    jmex_word_t next_pc;
    jmex_word_t move_value;
    logic dst_write;
    modport core (output instr, output pc, output sr, output src,
                  input kind, input taken, input next_pc, input move_value, input dst_write);
    modport unit (input instr, input pc, input sr, input src,
                  output kind, output taken, output next_pc, output move_value, output dst_write);
endinterface

// [verilog/jmex_branch_unit.sv]
`timescale 1ns/1ps
`include "jmex_map.svh"
module jmex_branch_unit
    import jmex_pkg::*;
(
    // decode side
    jmex_exec_if.unit ex
);
    logic cond_ok;
    logic c_f;
    logic z_f;
    logic n_f;
    logic v_f;
    jmex_word_t seq_pc;
    jmex_word_t offs;

    // ==========================================
    // flags and addresses
    assign c_f = ex.sr[`JMEX_SR_C];
    assign z_f = ex.sr[`JMEX_SR_Z];
    assign n_f = ex.sr[`JMEX_SR_N];
    assign v_f = ex.sr[`JMEX_SR_V];
    // every handled instruction is one word long
    assign seq_pc = ex.pc + `JMEX_INSTR_STEP;
    // sign-extend and double: 10-bit field reaches -512..+511 words of seq_pc
    assign offs = {{5{ex.instr[9]}}, ex.instr[9:0], 1'b0};

    // ==========================================
    // condition test
    always_comb begin
        case (ex.instr[12:10])
            `JMEX_COND_NE: cond_ok = ~z_f;
            `JMEX_COND_EQ: cond_ok = z_f;
            `JMEX_COND_NC: cond_ok = ~c_f;
            `JMEX_COND_C: cond_ok = c_f;
            `JMEX_COND_N: cond_ok = n_f;
            `JMEX_COND_GE: cond_ok = ~(n_f ^ v_f);
            `JMEX_COND_L: cond_ok = n_f ^ v_f;
            `JMEX_COND_AL: cond_ok = 1'b1;
            default: cond_ok = 1'b0;
        endcase
    end

    // ==========================================
    // classify and compute results
    always_comb begin
        ex.kind = jmex_kind_other;
        ex.taken = 1'b0;
        ex.next_pc = ex.pc;
        ex.move_value = ex.src;
        ex.dst_write = 1'b0;
        if (ex.instr[15:13] == `JMEX_JUMP_OP) begin
            ex.kind = jmex_kind_jump;
            ex.taken = cond_ok;
            ex.next_pc = cond_ok ? seq_pc + offs : seq_pc;
        end else if (ex.instr == `JMEX_IDLE_WORD) begin
            // constant-generator target swallows the write
            ex.kind = jmex_kind_idle;
            ex.next_pc = seq_pc;
        end else if (ex.instr[15:12] == `JMEX_MOVE_OP) begin
            ex.kind = jmex_kind_move;
            ex.next_pc = seq_pc;
            ex.dst_write = (ex.instr[3:0] != `JMEX_CG_REG);
            if (ex.instr[`JMEX_MOVE_BYTE]) begin
                ex.move_value = {8'h00, ex.src[7:0]};
            end
        end
    end
endmodule

// [dv/jmex_core_asserts.sv]
`timescale 1ns/1ps
`include "jmex_map.svh"
module jmex_core_asserts (
    // clock and reset
    input logic clk,
    input logic rst,
    // write side
    input logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid, s_axi_bready,
    // read side
    input logic [`JMEX_AXI_AW-1:0] s_axi_araddr,
    input logic s_axi_arvalid, s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    input logic s_axi_rvalid, s_axi_rready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ==========================================
    // read channel steps
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_rd_wait;
        s_axi_rvalid && !s_axi_arready;
    endsequence
    property p_rd_answer;
        s_rd_take |=> s_rd_wait;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped");
    property p_rd_release;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
    endproperty
    a_rd_release: assert property (p_rd_release) else $error("read not released");
    property p_rd_upper;
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read half not zero");
    property p_rd_unmapped;
        s_rd_take ##0 (s_axi_araddr > 8'h14) |=> s_axi_rresp == `JMEX_RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read accepted");

    // ==========================================
    // write channel steps
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    property p_wr_answer;
        s_wr_both |=> !s_axi_bvalid && !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer timing wrong");
    property p_wr_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
    property p_wr_release;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
    endproperty
    a_wr_release: assert property (p_wr_release) else $error("write not released");
    property p_wr_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_wr_block: assert property (p_wr_block) else $error("second write accepted");
endmodule

bind jmex_core jmex_core_asserts i_jmex_core_asserts (.clk(clk), .rst(rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// [dv/jmex_core_test.sv]
`timescale 1ns/1ps
`include "jmex_map.svh"
module jmex_core_test;
    import jmex_pkg::*;
    // ==========================================
    // clock, reset and bus signals
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int mismatches = 0, n_tests = 0, cycles = 0;
    logic [31:0] lfsr_q = 32'h3a06ef48;
    logic [15:0] ops[6] = '{16'h4405, 16'h4445, 16'h4403, 16'h4303, 16'h0000, 16'hf123};

    always #25 clk = ~clk;

    jmex_core i_jmex_core (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // ==========================================
    // helpers
    function logic [15:0] rnd();
        lfsr_q = {lfsr_q[30:0], 1'b0} ^ (lfsr_q[31] ? 32'h04c11db7 : 32'h0);
        return lfsr_q[15:0];
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // master holds each channel until its own ready, then waits for the answer
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= {rnd(), d}; // upper lanes must be ignored
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        chk("bresp", {30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e, input logic [1:0] er);
        logic [31:0] d;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        d = rdata;
        chk("rresp", {30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
        chk("rdata", d & {16'h0, m}, {16'h0, e});
    endtask

    // ==========================================
    // reference model of one executed word
    task automatic run(input logic [15:0] ins, input logic [15:0] sr, input logic [15:0] pc);
        logic [15:0] src, dst, pe, de;
        logic t;
        int off;
        src = rnd();
        dst = rnd();
        wr(8'h08, sr, `JMEX_RESP_OKAY);
        wr(8'h0c, src, `JMEX_RESP_OKAY);
        wr(8'h10, dst, `JMEX_RESP_OKAY);
        wr(8'h04, pc, `JMEX_RESP_OKAY);
        wr(8'h00, ins, `JMEX_RESP_OKAY);
        if (ins[15:13] == 3'b001) begin
            case (ins[12:10])
                3'h0: t = !sr[1];
                3'h1: t = sr[1];
                3'h2: t = !sr[0];
                3'h3: t = sr[0];
                3'h4: t = sr[2];
                3'h5: t = (sr[2] == sr[8]);
                3'h6: t = (sr[2] != sr[8]);
                default: t = 1'b1;
            endcase
            off = ins[9] ? int'(ins[9:0]) - 1024 : int'(ins[9:0]);
            pe = 16'(int'(pc) + 2 + (t ? 2 * off : 0));
            rdchk(8'h04, 16'hffff, pe, 2'h0);
            rdchk(8'h14, 16'hffff, {14'h0, 1'b1, t}, 2'h0);
        end else if (ins == 16'h4303) begin
            rdchk(8'h04, 16'hffff, pc + 16'h0002, 2'h0);
            rdchk(8'h14, 16'hffff, 16'h0008, 2'h0);
        end else if (ins[15:12] == 4'h4) begin
            de = (ins[3:0] == 4'h3) ? dst : (ins[6] ? {8'h00, src[7:0]} : src);
            rdchk(8'h04, 16'hffff, pc + 16'h0002, 2'h0);
            rdchk(8'h14, 16'hffff, 16'h0004, 2'h0);
        end else begin
            rdchk(8'h04, 16'hffff, pc, 2'h0);
            rdchk(8'h14, 16'hffff, 16'h0010, 2'h0);
        end
        if (ins[15:13] != 3'b001 && ins[15:12] != 4'h4) de = dst;
        if (ins[15:13] == 3'b001 || ins == 16'h4303) de = dst;
        rdchk(8'h10, 16'hffff, de, 2'h0);
        rdchk(8'h0c, 16'hffff, src, 2'h0);
        rdchk(8'h08, 16'hffff, sr, 2'h0);
    endtask

    // ==========================================
    // closing report, shared by the main flow and the watchdog
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // watchdog: the whole sequence needs well under this many cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            print_verdict();
        end
    end

    // ==========================================
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a <= 20; a += 4) rdchk(8'(a), 16'hffff, 16'h0000, 2'h0);
        // every condition against every carry, zero, negative, overflow mix
        for (int c = 0; c < 8; c++) begin
            for (int k = 0; k < 16; k++) begin
                run({3'b001, 3'(c), 10'(rnd())}, (rnd() & 16'hfef8) | {7'h0, 1'(k >> 3), 5'h0, 3'(k)}, rnd());
            end
        end
        run(16'h3dff, rnd(), 16'h8000);
        run(16'h3e00, rnd(), 16'h0010);
        foreach (ops[i]) run(ops[i], rnd(), rnd());
        // status word is read-only, unmapped places answer with an error
        wr(8'h14, 16'hffef, `JMEX_RESP_OKAY);
        rdchk(8'h14, 16'hffff, 16'h0010, 2'h0);
        // only the strobed byte lane of a register moves
        wr(8'h04, 16'h1234, `JMEX_RESP_OKAY);
        wstrb <= 4'h2;
        wr(8'h04, 16'hab12, `JMEX_RESP_OKAY);
        wstrb <= 4'hf;
        rdchk(8'h04, 16'hffff, 16'hab34, 2'h0);
        wr(8'h18, rnd(), `JMEX_RESP_SLVERR);
        rdchk(8'h18, 16'hffff, 16'h0000, `JMEX_RESP_SLVERR);
        print_verdict();
    end
endmodule
